//--- common/atr_map.vh
// Register map, field positions, codes and timing constants for the trigger router
`ifndef ATR_MAP_VH
`define ATR_MAP_VH

// Register addresses
`define ATR_ADDR_CTRL 4'h0
`define ATR_ADDR_THRESH 4'h1
`define ATR_ADDR_ROUTE 4'h2
`define ATR_ADDR_SCAN_DIV 4'h3
`define ATR_ADDR_CONV_DIV 4'h4
`define ATR_ADDR_UPD_DIV 4'h5
`define ATR_ADDR_STATUS 4'h6

// Control register fields
`define ATR_CTRL_SRC 0
`define ATR_CTRL_COND_LSB 1
`define ATR_CTRL_MODE_LSB 4
`define ATR_CTRL_POL 6
`define ATR_CTRL_MASTER 7
`define ATR_CTRL_SWTRIG 8
`define ATR_CTRL_SWRST 9

// Threshold register fields
`define ATR_THR_LOW_LSB 0
`define ATR_THR_HIGH_LSB 8

// Route register fields, two bits each
`define ATR_RT_TB_LSB 0
`define ATR_RT_CONV_LSB 2
`define ATR_RT_SCAN_LSB 4
`define ATR_RT_STRB_LSB 6
`define ATR_RT_OTRIG_LSB 8
`define ATR_RT_UPD_LSB 10

// Reset values
`define ATR_CTRL_RST 16'h0000
`define ATR_THRESH_RST 16'hc040
`define ATR_ROUTE_RST 16'h0000
`define ATR_DIV_RST 16'h0028

// Trigger conditions
`define ATR_COND_BELOW 3'h0
`define ATR_COND_ABOVE 3'h1
`define ATR_COND_INSIDE 3'h2
`define ATR_COND_HIHYS 3'h3
`define ATR_COND_LOHYS 3'h4

// Acquisition trigger modes
`define ATR_MODE_POST 2'h0
`define ATR_MODE_PRE 2'h1
`define ATR_MODE_MIDDLE 2'h2
`define ATR_MODE_DELAY 2'h3

// Source codes for timebase and strobes
`define ATR_SRC_INTERNAL 2'h0
`define ATR_SRC_EXTERNAL 2'h1
`define ATR_SRC_LINK 2'h2

// Source codes for triggers
`define ATR_TRG_DIGITAL 2'h0
`define ATR_TRG_ANALOG 2'h1
`define ATR_TRG_SOFTWARE 2'h2
`define ATR_TRG_LINK 2'h3

// Threshold code scale: zero volts and valid extremes
`define ATR_CODE_ZERO 8'h80
`define ATR_CODE_MIN 8'h01
`define ATR_CODE_MAX 8'hff

// Sync link bit positions
`define ATR_LNK_TB 0
`define ATR_LNK_CONV_TRIG 1
`define ATR_LNK_SCAN 2
`define ATR_LNK_STROBE 3
`define ATR_LNK_OTRIG 4
`define ATR_LNK_UPDATE 5
`define ATR_LNK_W 6

// Synchroniser input positions
`define ATR_IN_DTRIG 0
`define ATR_IN_EXTTB 1
`define ATR_IN_AUX0 2
`define ATR_IN_AUX1 3
`define ATR_IN_LINK 4
`define ATR_NSYNC 10

// Clock and oscillator rates in kHz
`define ATR_CLK_KHZ 50000
`define ATR_OSC_KHZ 40000

`endif

//--- src/atr_edge_sync.v
// Two-stage synchroniser with one-cycle rise and fall pulses
`include "atr_map.vh"

module atr_edge_sync (
   input wire clk_in, // System clock
   input wire rst_n_in, // Synchronised reset, active low
   input wire [`ATR_NSYNC-1:0] raw_in, // Asynchronous inputs
   output wire [`ATR_NSYNC-1:0] rise_out, // One-cycle rising-edge pulses
   output wire [`ATR_NSYNC-1:0] fall_out // One-cycle falling-edge pulses
);

   reg [`ATR_NSYNC-1:0] meta_q;
   reg [`ATR_NSYNC-1:0] sync_q;
   reg [`ATR_NSYNC-1:0] last_q;

   // First stage feeds only the second stage
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= {`ATR_NSYNC{1'b0}};
         sync_q <= {`ATR_NSYNC{1'b0}};
         last_q <= {`ATR_NSYNC{1'b0}};
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edge pulses from the settled stages
   assign rise_out = sync_q & ~last_q;
   assign fall_out = ~sync_q & last_q;

endmodule // atr_edge_sync

//--- src/atr_analog_cond.v
// Threshold comparison for the five analog trigger conditions
`include "atr_map.vh"

module atr_analog_cond (
   input wire clk_in, // System clock
   input wire rst_n_in, // Synchronised reset, active low
   input wire soft_rst_in, // Software reset pulse
   input wire enable_in, // Source accepted in the current mode
   input wire [7:0] sample_in, // Source code, offset binary
   input wire [7:0] low_in, // Low threshold code
   input wire [7:0] high_in, // High threshold code
   input wire [2:0] cond_in, // Trigger condition
   output reg level_out // Trigger level
);

   reg level_d;
   reg below;
   reg above;

   // Offset-binary codes compare as unsigned numbers
   always @* begin
      below = (sample_in < low_in);
      above = (sample_in > high_in);
      level_d = 1'b0;
      case (cond_in)
         `ATR_COND_BELOW: begin
            level_d = below;
         end
         `ATR_COND_ABOVE: begin
            level_d = above;
         end
         `ATR_COND_INSIDE: begin
            level_d = (sample_in > low_in) && (sample_in < high_in);
         end
         `ATR_COND_HIHYS: begin
            // Fires above high, re-arms only below low
            level_d = level_out ? ~below : above;
         end
         `ATR_COND_LOHYS: begin
            // Fires below low, re-arms only above high
            level_d = level_out ? ~above : below;
         end
         default: begin
            level_d = 1'b0;
         end
      endcase
      if (!enable_in) begin
         level_d = 1'b0;
      end
   end

   // Trigger level register
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= 1'b0;
      end else if (soft_rst_in) begin
         level_out <= 1'b0;
      end else begin
         level_out <= level_d;
      end
   end

endmodule // atr_analog_cond

//--- src/atr_top.v
// Trigger and timing-signal router for a multi-channel acquisition card
//
// Overview of operation
// - Analog source select picks the external trigger pin or first queued channel.
// - Source two only works in post and delay modes; otherwise it is refused.
// - Source one codes are linear: 0x80 zero, 0xFF top, 0x01 bottom.
// - Source two codes span the first channel range in 256 steps.
// - Five trigger conditions built from a low and a high threshold.
// - Below-low: trigger while source is under low; high ignored.
// - Above-high: trigger while source exceeds high; low ignored.
// - Inside-region: trigger while source is between low and high.
// - High hysteresis: fire rising above high; low bounds the band.
// - Low hysteresis: fire falling under low; high bounds the band.
// - Digital trigger fires on the chosen edge; serves conversion and output triggers.
// - Timebase from internal oscillator, external input or sync link.
// - Conversion trigger from digital, analog, software or sync link.
// - Scan start from counter, aux zero or link; timebase-aligned; starts strobes.
// - Conversion strobe from counter, aux zero or link; one per rising edge.
// - Output trigger from digital, analog, software or sync link.
// - Update strobe from counter, aux one or link; one per rising edge.
// - Each timing signal has its own mux and can be driven out.
// - Master drives the sync link; slave substitutes the received signals.
// - Aux zero serves either strobe or scan start, never both.
`include "atr_map.vh"

module atr_top (
   input wire mclk_in, // 50 MHz system clock
   input wire reset_n_in, // Asynchronous reset, active low
   input wire [3:0] addr_in, // Register address
   input wire [15:0] wdata_in, // Register write data
   input wire wr_in, // Write strobe
   input wire rd_in, // Read strobe
   output reg [15:0] rdata_out, // Read data, cycle after the strobe
   input wire [7:0] analog_source_one_in, // Trigger pin code
   input wire [7:0] analog_source_two_in, // First queued channel code
   input wire ext_digital_trigger_pin_in, // External digital trigger
   input wire external_timebase_input_in, // External timebase
   input wire aux_input_zero_in, // Auxiliary input zero
   input wire aux_input_one_in, // Auxiliary input one
   input wire [5:0] sync_link_in, // Sync link pins, received level
   output reg [5:0] sync_link_out, // Sync link pins, driven level
   output reg [5:0] sync_link_oe_out, // Sync link output enables
   output reg timebase_tick_out, // Selected timebase pulse
   output reg conversion_trigger_out, // Conversion trigger pulse
   output reg scan_begin_out, // Scan start pulse
   output reg sample_convert_strobe_out, // Conversion strobe pulse
   output reg output_trigger_out, // Output trigger pulse
   output reg output_update_strobe_out, // Output update pulse
   output reg analog_trigger_out // Analog trigger level
);

   // Four-way pulse select used by every source mux
   function pick4;
      input [1:0] sel;
      input a;
      input b;
      input c;
      input d;
      begin
         case (sel)
            2'h0: pick4 = a;
            2'h1: pick4 = b;
            2'h2: pick4 = c;
            default: pick4 = d;
         endcase
      end
   endfunction

   // Down-counter step: reload at zero
   function [15:0] count_next;
      input [15:0] cnt;
      input [15:0] div;
      begin
         if (cnt == 16'h0000) begin
            count_next = div - 16'h0001;
         end else begin
            count_next = cnt - 16'h0001;
         end
      end
   endfunction

   reg [1:0] rst_sync_q;
   wire rst_n;
   reg [15:0] ctrl_q;
   reg [15:0] thresh_q;
   reg [15:0] route_q;
   reg [15:0] scan_div_q;
   reg [15:0] conv_div_q;
   reg [15:0] upd_div_q;
   reg sw_trig_q;
   reg sw_rst_q;
   wire [`ATR_NSYNC-1:0] rise;
   wire [`ATR_NSYNC-1:0] fall;
   wire [5:0] link_rise;
   reg [15:0] osc_acc_q;
   reg [15:0] osc_acc_d;
   reg osc_tick_d;
   reg tb_q;
   wire master;
   wire [1:0] tb_sel;
   wire [1:0] conv_sel;
   wire [1:0] scan_sel;
   wire [1:0] strb_sel;
   wire [1:0] otrig_sel;
   wire [1:0] upd_sel;
   wire [1:0] acq_mode;
   wire analog_source_two_ok;
   wire ana_enable;
   wire [7:0] ana_sample;
   wire ana_level;
   reg ana_last_q;
   wire ana_pulse;
   wire dtrig_pulse;
   wire aux0_conflict;
   wire conv_trig_d;
   wire out_trig_d;
   reg acq_run_q;
   reg out_run_q;
   reg scan_active_q;
   reg scan_pend_q;
   reg [15:0] scan_cnt_q;
   reg [15:0] conv_cnt_q;
   reg [15:0] upd_cnt_q;
   wire scan_int;
   wire scan_src;
   wire scan_fire;
   wire conv_int;
   wire strobe_d;
   wire upd_int;
   wire upd_d;

   // Reset release through two flops
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Register writes; trigger and reset bits are self-clearing pulses
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `ATR_CTRL_RST;
         thresh_q <= `ATR_THRESH_RST;
         route_q <= `ATR_ROUTE_RST;
         scan_div_q <= `ATR_DIV_RST;
         conv_div_q <= `ATR_DIV_RST;
         upd_div_q <= `ATR_DIV_RST;
         sw_trig_q <= 1'b0;
         sw_rst_q <= 1'b0;
      end else begin
         sw_trig_q <= wr_in && (addr_in == `ATR_ADDR_CTRL) && wdata_in[`ATR_CTRL_SWTRIG];
         sw_rst_q <= wr_in && (addr_in == `ATR_ADDR_CTRL) && wdata_in[`ATR_CTRL_SWRST];
         if (wr_in) begin
            case (addr_in)
               `ATR_ADDR_CTRL: ctrl_q <= {8'h00, wdata_in[7:0]};
               `ATR_ADDR_THRESH: thresh_q <= wdata_in;
               `ATR_ADDR_ROUTE: route_q <= {4'h0, wdata_in[11:0]};
               `ATR_ADDR_SCAN_DIV: scan_div_q <= wdata_in;
               `ATR_ADDR_CONV_DIV: conv_div_q <= wdata_in;
               `ATR_ADDR_UPD_DIV: upd_div_q <= wdata_in;
               default: ctrl_q <= ctrl_q;
            endcase
         end
      end
   end

   // Read data stand for one cycle only; unmapped addresses read zero
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= 16'h0000;
      end else if (rd_in) begin
         case (addr_in)
            `ATR_ADDR_CTRL: rdata_out <= ctrl_q;
            `ATR_ADDR_THRESH: rdata_out <= thresh_q;
            `ATR_ADDR_ROUTE: rdata_out <= route_q;
            `ATR_ADDR_SCAN_DIV: rdata_out <= scan_div_q;
            `ATR_ADDR_CONV_DIV: rdata_out <= conv_div_q;
            `ATR_ADDR_UPD_DIV: rdata_out <= upd_div_q;
            `ATR_ADDR_STATUS: rdata_out <= {9'h000, aux0_conflict, ~ana_enable,
               scan_active_q, out_run_q, acq_run_q, master, ana_level};
            default: rdata_out <= 16'h0000;
         endcase
      end else begin
         rdata_out <= 16'h0000;
      end
   end

   // Field decode
   assign master = ctrl_q[`ATR_CTRL_MASTER];
   assign acq_mode = ctrl_q[`ATR_CTRL_MODE_LSB+1:`ATR_CTRL_MODE_LSB];
   assign tb_sel = route_q[`ATR_RT_TB_LSB+1:`ATR_RT_TB_LSB];
   assign conv_sel = route_q[`ATR_RT_CONV_LSB+1:`ATR_RT_CONV_LSB];
   assign scan_sel = route_q[`ATR_RT_SCAN_LSB+1:`ATR_RT_SCAN_LSB];
   assign strb_sel = route_q[`ATR_RT_STRB_LSB+1:`ATR_RT_STRB_LSB];
   assign otrig_sel = route_q[`ATR_RT_OTRIG_LSB+1:`ATR_RT_OTRIG_LSB];
   assign upd_sel = route_q[`ATR_RT_UPD_LSB+1:`ATR_RT_UPD_LSB];

   // Digital trigger, external timebase, aux and link inputs share one synchroniser bank
   atr_edge_sync u_sync (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .raw_in({sync_link_in, aux_input_one_in, aux_input_zero_in,
         external_timebase_input_in, ext_digital_trigger_pin_in}),
      .rise_out(rise),
      .fall_out(fall)
   );

   // A slave substitutes link signals; a master ignores its own echo
   assign link_rise = master ? 6'h00 : rise[`ATR_NSYNC-1:`ATR_IN_LINK];

   // Internal oscillator rate derived from the system clock by a phase accumulator
   always @* begin
      if (osc_acc_q + `ATR_OSC_KHZ >= `ATR_CLK_KHZ) begin
         osc_acc_d = osc_acc_q + 16'd`ATR_OSC_KHZ - 16'd`ATR_CLK_KHZ;
         osc_tick_d = 1'b1;
      end else begin
         osc_acc_d = osc_acc_q + 16'd`ATR_OSC_KHZ;
         osc_tick_d = 1'b0;
      end
   end

   // Timebase select; an external timebase is seen by its sampled rising edges
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         osc_acc_q <= 16'h0000;
         tb_q <= 1'b0;
      end else begin
         osc_acc_q <= osc_acc_d;
         tb_q <= pick4(tb_sel, osc_tick_d, rise[`ATR_IN_EXTTB],
            link_rise[`ATR_LNK_TB], 1'b0);
      end
   end

   // Analog source select and mode check
   assign analog_source_two_ok = (acq_mode == `ATR_MODE_POST) || (acq_mode == `ATR_MODE_DELAY);
   assign ana_enable = ~ctrl_q[`ATR_CTRL_SRC] | analog_source_two_ok;
   assign ana_sample = ctrl_q[`ATR_CTRL_SRC] ? analog_source_two_in
      : analog_source_one_in;

   atr_analog_cond u_cond (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .soft_rst_in(sw_rst_q),
      .enable_in(ana_enable),
      .sample_in(ana_sample),
      .low_in(thresh_q[`ATR_THR_LOW_LSB+7:`ATR_THR_LOW_LSB]),
      .high_in(thresh_q[`ATR_THR_HIGH_LSB+7:`ATR_THR_HIGH_LSB]),
      .cond_in(ctrl_q[`ATR_CTRL_COND_LSB+2:`ATR_CTRL_COND_LSB]),
      .level_out(ana_level)
   );

   // Analog level turned into one pulse per assertion
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ana_last_q <= 1'b0;
      end else begin
         ana_last_q <= ana_level;
      end
   end
   assign ana_pulse = ana_level & ~ana_last_q;

   // Digital trigger on the programmed edge
   assign dtrig_pulse = ctrl_q[`ATR_CTRL_POL] ? fall[`ATR_IN_DTRIG]
      : rise[`ATR_IN_DTRIG];

   // Independent trigger muxes
   assign conv_trig_d = pick4(conv_sel, dtrig_pulse, ana_pulse, sw_trig_q,
      link_rise[`ATR_LNK_CONV_TRIG]);
   assign out_trig_d = pick4(otrig_sel, dtrig_pulse, ana_pulse, sw_trig_q,
      link_rise[`ATR_LNK_OTRIG]);

   // Aux zero belongs to the strobe when both ask for it
   assign aux0_conflict = (strb_sel == `ATR_SRC_EXTERNAL)
      && (scan_sel == `ATR_SRC_EXTERNAL);

   // Internal counters tick on the selected timebase
   assign scan_int = acq_run_q && tb_q && (scan_cnt_q == 16'h0000);
   assign conv_int = scan_active_q && tb_q && (conv_cnt_q == 16'h0000);
   assign upd_int = out_run_q && tb_q && (upd_cnt_q == 16'h0000);

   // Scan start source; aux zero refused while it serves the strobe
   assign scan_src = pick4(scan_sel, scan_int,
      rise[`ATR_IN_AUX0] & ~aux0_conflict, link_rise[`ATR_LNK_SCAN], 1'b0);
   // Scan start is released on the next timebase tick
   assign scan_fire = scan_pend_q & tb_q;

   // Strobe muxes; each rising edge gives exactly one pulse
   assign strobe_d = pick4(strb_sel, conv_int, rise[`ATR_IN_AUX0],
      link_rise[`ATR_LNK_STROBE], 1'b0);
   assign upd_d = pick4(upd_sel, upd_int, rise[`ATR_IN_AUX1],
      link_rise[`ATR_LNK_UPDATE], 1'b0);

   // Run state and counters; software reset restarts them, while the timebase and the registers run on
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         acq_run_q <= 1'b0;
         out_run_q <= 1'b0;
         scan_active_q <= 1'b0;
         scan_pend_q <= 1'b0;
         scan_cnt_q <= 16'h0000;
         conv_cnt_q <= 16'h0000;
         upd_cnt_q <= 16'h0000;
      end else if (sw_rst_q) begin
         acq_run_q <= conv_trig_d;
         out_run_q <= out_trig_d;
         scan_active_q <= 1'b0;
         scan_pend_q <= 1'b0;
         scan_cnt_q <= 16'h0000;
         conv_cnt_q <= 16'h0000;
         upd_cnt_q <= 16'h0000;
      end else begin
         if (conv_trig_d) begin
            acq_run_q <= 1'b1;
         end
         if (out_trig_d) begin
            out_run_q <= 1'b1;
         end
         // A new source pulse wins over the release of the pending one
         scan_pend_q <= (scan_pend_q & ~scan_fire) | scan_src;
         if (acq_run_q && tb_q) begin
            scan_cnt_q <= count_next(scan_cnt_q, scan_div_q);
         end
         // Scan start restarts the strobe counter
         if (scan_fire) begin
            scan_active_q <= 1'b1;
            conv_cnt_q <= 16'h0000;
         end else if (scan_active_q && tb_q) begin
            conv_cnt_q <= count_next(conv_cnt_q, conv_div_q);
         end
         if (out_run_q && tb_q) begin
            upd_cnt_q <= count_next(upd_cnt_q, upd_div_q);
         end
      end
   end

   // Registered outputs and sync link drive
   always @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         timebase_tick_out <= 1'b0;
         conversion_trigger_out <= 1'b0;
         scan_begin_out <= 1'b0;
         sample_convert_strobe_out <= 1'b0;
         output_trigger_out <= 1'b0;
         output_update_strobe_out <= 1'b0;
         analog_trigger_out <= 1'b0;
         sync_link_out <= 6'h00;
         sync_link_oe_out <= 6'h00;
      end else begin
         timebase_tick_out <= tb_q;
         conversion_trigger_out <= conv_trig_d;
         scan_begin_out <= scan_fire & ~sw_rst_q;
         sample_convert_strobe_out <= strobe_d & ~sw_rst_q;
         output_trigger_out <= out_trig_d;
         output_update_strobe_out <= upd_d & ~sw_rst_q;
         analog_trigger_out <= ana_level;
         // Master sends its own timing out; slave leaves the pins free
         sync_link_out <= master ? {upd_d, out_trig_d, strobe_d, scan_fire,
            conv_trig_d, tb_q} : 6'h00;
         sync_link_oe_out <= {6{master}};
      end
   end

endmodule // atr_top

//--- sim/atr_far_model.sv
// Far-side model: trigger source, auxiliary inputs and a sibling card on the link
module atr_far_model (
   input wire logic clk_in, // Clock
   input wire logic [8:0] fire_in, // Pulse requests: trigger, aux0, aux1, link 0..5
   output logic [8:0] line_out // Driven lines in the same order
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_q [0:8];
   // Lines start idle
   initial begin
      for (int i = 0; i < 9; i++) cnt_q[i] = 3'h0;
   end
   // Each request gives a six-cycle pulse, longer than a timebase pulse and 20 ns
   always @(posedge clk_in) begin
      for (int i = 0; i < 9; i++) begin
         if (fire_in[i]) cnt_q[i] <= 3'h6;
         else if (cnt_q[i] != 3'h0) cnt_q[i] <= cnt_q[i] - 3'h1;
      end
   end
   // A line is high while its pulse runs
   always @* begin
      for (int i = 0; i < 9; i++) line_out[i] = cnt_q[i] != 3'h0;
   end
endmodule // atr_far_model

//--- sim/atr_top_asserts.sv
// Port-level checks for the trigger router
`include "atr_map.vh"
module atr_top_chk (
   input wire logic mclk_in, // Clock
   input wire logic reset_n_in, // Reset, active low
   input wire logic [3:0] addr_in, // Address
   input wire logic [15:0] wdata_in, // Write data
   input wire logic wr_in, // Write strobe
   input wire logic rd_in, // Read strobe
   input wire logic [15:0] rdata_out, // Read data
   input wire logic [7:0] analog_source_one_in, // Source one code
   input wire logic ext_digital_trigger_pin_in, // Digital trigger
   input wire logic aux_input_one_in, // Aux one
   input wire logic [5:0] sync_link_out, // Link data
   input wire logic [5:0] sync_link_oe_out, // Link enables
   input wire logic conversion_trigger_out, // Conversion trigger
   input wire logic output_update_strobe_out, // Update strobe
   input wire logic analog_trigger_out // Analog level
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [15:0] ctl_q, thr_q, rte_q;
   // Shadow copies of control, threshold and route
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctl_q <= `ATR_CTRL_RST;
         thr_q <= `ATR_THRESH_RST;
         rte_q <= `ATR_ROUTE_RST;
      end else if (wr_in) begin
         if (addr_in == `ATR_ADDR_CTRL) ctl_q <= wdata_in;
         if (addr_in == `ATR_ADDR_THRESH) thr_q <= wdata_in;
         if (addr_in == `ATR_ADDR_ROUTE) rte_q <= wdata_in;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
      else $error("read data outside its cycle");
   a_unmapped_read: assert property (rd_in && addr_in > `ATR_ADDR_STATUS |=> rdata_out == 0)
      else $error("unmapped read not zero");
   a_update_once: assert property (
      output_update_strobe_out |=> !output_update_strobe_out)
      else $error("update pulse longer than one cycle");
   a_aux1_update: assert property (
      rte_q[11:10] == 2'h1 && $rose(aux_input_one_in) |-> ##3 output_update_strobe_out)
      else $error("aux one edge gave no update");
   a_dtrig_edge: assert property (
      rte_q[3:2] == 2'h0 && (ctl_q[6] ? $fell(ext_digital_trigger_pin_in)
      : $rose(ext_digital_trigger_pin_in)) |-> ##3 conversion_trigger_out)
      else $error("digital edge gave no conversion trigger");
   a_below_low: assert property (
      (ctl_q[3:0] == 4'h0 && analog_source_one_in < thr_q[7:0])[*4] |=> analog_trigger_out)
      else $error("below-low level missing");
   a_above_high: assert property (
      (ctl_q[3:0] == 4'h2 && analog_source_one_in <= thr_q[15:8])[*4] |=> !analog_trigger_out)
      else $error("above-high level wrong");
   a_src_refused: assert property (
      (ctl_q[0] && ctl_q[5:4] == 2'h1)[*4] |=> !analog_trigger_out)
      else $error("source two accepted in pre mode");
   a_master_drive: assert property (ctl_q[7] [*3] |=> sync_link_oe_out == 6'h3f)
      else $error("master not driving link");
   a_slave_quiet: assert property (
      !ctl_q[7] [*3] |=> sync_link_oe_out == 6'h00 && sync_link_out == 6'h00)
      else $error("slave driving link");
endmodule // atr_top_chk
bind atr_top atr_top_chk u_chk (.*);

//--- sim/atr_top_tb_top.sv
// Self-checking bench for the trigger router
`include "atr_map.vh"
module atr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic external_timebase_input_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000, rdata_out;
   logic [7:0] analog_source_one_in = 8'h80, analog_source_two_in = 8'h80;
   wire ext_digital_trigger_pin_in, aux_input_zero_in, aux_input_one_in;
   wire [5:0] sync_link_in;
   wire [8:0] far_w;
   logic [5:0] sync_link_out, sync_link_oe_out;
   logic timebase_tick_out, conversion_trigger_out, scan_begin_out, sample_convert_strobe_out;
   logic output_trigger_out, output_update_strobe_out, analog_trigger_out;
   logic [8:0] fire_q = 9'h000;
   int num_errors = 0, n_tests = 0, lo = 8'h50, hi = 8'hb0, b, pc [0:5];
   wire [5:0] pv = {output_update_strobe_out, output_trigger_out, sample_convert_strobe_out,
      scan_begin_out, conversion_trigger_out, timebase_tick_out};
   assign {sync_link_in, aux_input_one_in, aux_input_zero_in, ext_digital_trigger_pin_in} = far_w;
   always #10 mclk_in = ~mclk_in;
   atr_top u_dut (.*);
   atr_far_model u_far (.clk_in(mclk_in), .fire_in(fire_q), .line_out(far_w));
   // Count output pulses away from the launching edge
   always @(negedge mclk_in) for (int i = 0; i < 6; i++) if (pv[i] === 1'b1) pc[i]++;
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 chk("rdata", rdata_out & m, e);
   endtask
   task automatic fire(input int k);
      @(posedge mclk_in);
      fire_q <= 9'h001 << k;
      @(posedge mclk_in);
      fire_q <= 9'h000;
   endtask
   // Bounded wait for n pulses on output k, then settle and compare
   task automatic wait_pc(input int k, input int n, input string nm);
      for (int t = 0; t < 80 && pc[k] < n; t++) @(posedge mclk_in);
      repeat (8) @(posedge mclk_in);
      chk(nm, pc[k], n);
   endtask
   // Drive samples and compare the level with the condition model
   task automatic analog(input int cond, input int analog_source_two, input int mode);
      int lvl, s;
      lvl = 0;
      wr(`ATR_ADDR_CTRL, 16'h0200 | (mode << 4) | (cond << 1) | analog_source_two);
      for (int i = 0; i < 16; i++) begin
         s = (i % 4 == 0) ? (i % 8 ? lo : hi) : $urandom % 256;
         @(posedge mclk_in);
         analog_source_one_in <= analog_source_two ? ~s[7:0] : s[7:0];
         analog_source_two_in <= analog_source_two ? s[7:0] : ~s[7:0];
         if (cond == 0) lvl = s < lo;
         else if (cond == 1) lvl = s > hi;
         else if (cond == 2) lvl = s > lo && s < hi;
         else if (cond == 3) lvl = s > hi ? 1 : (s < lo ? 0 : lvl);
         else lvl = s < lo ? 1 : (s > hi ? 0 : lvl);
         if (analog_source_two && mode == 1) lvl = 0;
         repeat (3) @(posedge mclk_in);
         #1 chk("analog", analog_trigger_out, lvl);
      end
   endtask
   task summarize;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      #1000000;
      num_errors++;
      summarize();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h51dd));
      repeat (10) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rd(`ATR_ADDR_CTRL, `ATR_CTRL_RST);
      rd(`ATR_ADDR_THRESH, `ATR_THRESH_RST);
      for (int a = 3; a < 6; a++) rd(a[3:0], `ATR_DIV_RST);
      rd(4'hf, 16'h0000);
      wr(`ATR_ADDR_ROUTE, 16'hffff);
      rd(`ATR_ADDR_ROUTE, 16'h0fff);
      wr(`ATR_ADDR_THRESH, 16'hb050);
      for (int c = 0; c < 5; c++) analog(c, 0, 0);
      analog(0, 1, 1);
      rd(`ATR_ADDR_STATUS, 16'h0020, 16'h0020);
      analog(0, 1, 3);
      wr(`ATR_ADDR_ROUTE, 16'h0640);
      for (int p = 0; p < 2; p++) begin
         wr(`ATR_ADDR_CTRL, p << 6);
         b = pc[1];
         fire(0);
         repeat (6) @(posedge mclk_in);
         chk("conv_near_rise", pc[1] - b, p ? 0 : 1);
         wait_pc(1, b + 1, "conv_count");
      end
      b = pc[0];
      repeat (50) @(posedge mclk_in);
      chk("tb", pc[0] - b, 40);
      wait_pc(2, pc[2] + 1, "scan_start");
      wr(`ATR_ADDR_ROUTE, 16'h0641);
      repeat (2) @(posedge mclk_in);
      b = pc[0];
      repeat (20) @(posedge mclk_in) external_timebase_input_in <= ~external_timebase_input_in;
      wait_pc(0, b + 10, "ext_tb");
      b = pc[5];
      pc[3] = 0;
      for (int n = 0; n < 3; n++) begin
         fire(2);
         fire(1);
         repeat (8) @(posedge mclk_in);
      end
      wait_pc(5, b + 3, "update_count");
      chk("strobe_count", pc[3], 3);
      wr(`ATR_ADDR_ROUTE, 16'h0648);
      b = pc[4];
      wr(`ATR_ADDR_CTRL, 16'h0100);
      wait_pc(4, b + 1, "otrig_count");
      wr(`ATR_ADDR_ROUTE, 16'h0050);
      rd(`ATR_ADDR_STATUS, 16'h0040, 16'h0040);
      wr(`ATR_ADDR_ROUTE, 16'h0800);
      b = pc[5];
      fire(8);
      wait_pc(5, b + 1, "link_update");
      wr(`ATR_ADDR_CTRL, 16'h0080);
      rd(`ATR_ADDR_STATUS, 16'h0002, 16'h0002);
      chk("link_oe", sync_link_oe_out, 6'h3f);
      b = pc[5];
      fire(8);
      wait_pc(5, b, "link_ignored");
      summarize();
   end
endmodule // atr_top_tb_top
